/* File: pkg/adc_frame_regs.vh */
// constants for the serial converter frame control
`ifndef ADC_FRAME_REGS_VH
`define ADC_FRAME_REGS_VH
`define INIT_MAX_EDGES 5'd8
`define SAMPLE_START_EDGE 5'd5
`define SAMPLE_LEN 5'd20
`define CONV_START_EDGE 5'd24
`define FRAME_BITS 5'd16
`define TRISTATE_EDGE 5'd17
`define CONV_OSC_CYCLES 5'd20
`define INIT_CODE 16'h3FC0
`define RESULT_BITS 14
`define OSC_DIV_DEFAULT 4'h5
`define FIFO_DEPTH 32
`define FIFO_WIDTH 14
`endif

/* File: hw/result_fifo.v */
// parameterised fifo holding converter results
`timescale 1ns/10ps
module result_fifo #(
    parameter WIDTH = 14,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire ref_clk, // system clock
    input wire rstn, // async reset, active low
    input wire in_valid, // write request
    output wire in_ready, // space available
    input wire [WIDTH-1:0] in_data, // write word
    output wire out_valid, // data available
    input wire out_ready, // reader accepts
    output wire [WIDTH-1:0] out_data // head word
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    wire [AW:0] fill;
    wire do_wr;
    wire do_rd;

    // full and empty from pointer difference
    assign fill = wr_ptr - rd_ptr;
    assign in_ready = (fill != DEPTH[AW:0]);
    assign out_valid = (fill != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;

    // storage array, no reset needed
    always @(posedge ref_clk)
    begin
        if (do_wr)
            mem[wr_ptr[AW-1:0]] <= in_data;
    end

    // pointer update
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end
        else
        begin
            if (do_wr)
                wr_ptr <= wr_ptr + 1'b1;
            if (do_rd)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end
endmodule // result_fifo

/* File: hw/serial_adc_frame_control.v */
// frame, sampling and conversion control of a serial 14-bit converter
`timescale 1ns/10ps
`include "adc_frame_regs.vh"
module serial_adc_frame_control (
    input wire ref_clk, // 50 MHz system clock
    input wire rstn, // async reset, active low
    input wire sclk, // serial clock from host
    input wire cs_n, // chip select, active low
    input wire frame_sync_input, // frame sync, tie high when unused
    output reg sdo_out, // serial data output value
    output reg sdo_oe, // serial data output enable
    input wire [13:0] analog_code, // digitised input level, straight binary
    output reg sampling, // sampling window active
    output reg converting, // conversion in progress
    output reg powered_down, // auto power-down state
    output reg [13:0] result_bits, // head of result fifo
    output reg result_valid, // result_bits holds a word
    input wire result_ready // consumer takes result_bits
);
    // synchronisers: first stage read only by second
    reg [1:0] sclk_s;
    reg [1:0] cs_s;
    reg [1:0] fs_s;
    reg sclk_d;
    reg cs_d;
    reg fs_d;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_fall;
    wire cs_rise;
    wire fs_rise;
    wire fs_fall;
    wire fs_mode;

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sclk_s <= 2'b00;
            cs_s <= 2'b11;
            fs_s <= 2'b11;
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
            fs_d <= 1'b1;
        end
        else
        begin
            sclk_s <= {sclk_s[0], sclk};
            cs_s <= {cs_s[0], cs_n};
            fs_s <= {fs_s[0], frame_sync_input};
            sclk_d <= sclk_s[1];
            cs_d <= cs_s[1];
            fs_d <= fs_s[1];
        end
    end

    // edge detection on the second stage
    assign sclk_rise = sclk_s[1] && !sclk_d;
    assign sclk_fall = !sclk_s[1] && sclk_d;
    assign cs_fall = !cs_s[1] && cs_d;
    assign cs_rise = cs_s[1] && !cs_d;
    assign fs_rise = fs_s[1] && !fs_d;
    assign fs_fall = !fs_s[1] && fs_d;
    // sync rises only start a frame while select is low
    assign fs_mode = !cs_s[1];

    // free oscillator divider standing in for the internal conversion clock
    reg [3:0] osc_div;
    reg osc_tick;
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            osc_div <= 4'h0;
            osc_tick <= 1'b0;
        end
        else if (osc_div == `OSC_DIV_DEFAULT - 4'h1)
        begin
            osc_div <= 4'h0;
            osc_tick <= 1'b1;
        end
        else
        begin
            osc_div <= osc_div + 4'h1;
            osc_tick <= 1'b0;
        end
    end

    // frame bookkeeping
    reg active;
    reg [4:0] fall_cnt;
    reg [4:0] rise_cnt;
    reg [15:0] shift;
    reg [15:0] next_word;
    reg [13:0] sample_hold;
    reg [4:0] conv_cnt;
    reg conv_done_ok;
    reg init_pending;
    reg fifo_push;
    reg [13:0] fifo_word;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [13:0] fifo_out_data;
    wire start_cs;
    wire start_fs;
    wire frame_start;
    wire frame_end;

    // select fall with sync high, or sync rise while select low
    // select fall starts only with sync high
    assign start_cs = cs_fall && fs_s[1];
    assign start_fs = fs_mode && fs_rise;
    assign frame_start = (start_cs || start_fs) && !active;
    assign frame_end = active && (cs_rise || (fs_rise && !start_fs));

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            active <= 1'b0;
            fall_cnt <= 5'd0;
            rise_cnt <= 5'd0;
            shift <= 16'h0000;
            next_word <= `INIT_CODE;
            sample_hold <= 14'h0000;
            conv_cnt <= 5'd0;
            converting <= 1'b0;
            conv_done_ok <= 1'b0;
            init_pending <= 1'b0;
            sampling <= 1'b0;
            powered_down <= 1'b1;
            sdo_out <= 1'b0;
            sdo_oe <= 1'b0;
            fifo_push <= 1'b0;
            fifo_word <= 14'h0000;
        end
        else
        begin
            fifo_push <= 1'b0;
            if (converting && osc_tick)
            begin
                if (conv_cnt == `CONV_OSC_CYCLES - 5'd1)
                begin
                    converting <= 1'b0;
                    conv_done_ok <= 1'b1;
                    powered_down <= 1'b1;
                    next_word <= {sample_hold, 2'b00};
                    fifo_word <= sample_hold;
                    fifo_push <= fifo_in_ready;
                end
                conv_cnt <= conv_cnt + 5'd1;
            end
            if (frame_start)
            begin
                active <= 1'b1;
                powered_down <= 1'b0;
                fall_cnt <= 5'd0;
                rise_cnt <= 5'd0;
                if (converting)
                begin
                    converting <= 1'b0;
                    next_word <= `INIT_CODE;
                    shift <= `INIT_CODE;
                    sdo_out <= 1'b0;
                end
                else
                begin
                    shift <= next_word;
                    sdo_out <= next_word[15];
                end
                if (init_pending)
                begin
                    shift <= `INIT_CODE;
                    sdo_out <= 1'b0;
                    init_pending <= 1'b0;
                end
                sdo_oe <= 1'b1;
            end
            else if (active)
            begin
                if (sclk_rise)
                begin
                    rise_cnt <= rise_cnt + 5'd1;
                    if (rise_cnt + 5'd1 >= `TRISTATE_EDGE)
                        sdo_oe <= 1'b0;
                    else if (rise_cnt != 5'd0)
                    begin
                        shift <= {shift[14:0], 1'b0};
                        sdo_out <= shift[14];
                    end
                end
                if (sclk_fall)
                begin
                    fall_cnt <= fall_cnt + 5'd1;
                    if (fall_cnt + 5'd1 == `SAMPLE_START_EDGE - 5'd1)
                        sampling <= 1'b1;
                    if (fall_cnt + 5'd1 == `CONV_START_EDGE)
                    begin
                        sampling <= 1'b0;
                        sample_hold <= analog_code;
                        converting <= 1'b1;
                        conv_cnt <= 5'd0;
                        conv_done_ok <= 1'b0;
                        active <= 1'b0;
                    end
                end
                if (frame_end)
                begin
                    active <= 1'b0;
                    sampling <= 1'b0;
                    sdo_oe <= 1'b0;
                    // 1 to 8 falls is init
                    if (fall_cnt >= 5'd1 && fall_cnt <= `INIT_MAX_EDGES)
                        init_pending <= 1'b1;
                    powered_down <= 1'b1;
                end
            end
            else if (cs_rise)
                sdo_oe <= 1'b0;
        end
    end

    // result stream, back-pressured by result_ready
    wire pop;
    assign pop = fifo_out_valid && (!result_valid || result_ready);
    result_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH),
        .AW(5)
    ) u_fifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(fifo_word),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data)
    );

    // output register stage of the stream
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            result_bits <= 14'h0000;
            result_valid <= 1'b0;
        end
        else if (pop)
        begin
            result_bits <= fifo_out_data;
            result_valid <= 1'b1;
        end
        else if (result_ready)
            result_valid <= 1'b0;
    end
endmodule // serial_adc_frame_control

/* File: dv/serial_adc_frame_control_chk.sv */
// port assertions for the converter frame control
`timescale 1ns/10ps
module serial_adc_frame_control_chk (
    input wire logic ref_clk, // clock
    input wire logic rstn, // reset
    input wire logic sclk, // link clock
    input wire logic cs_n, // select
    input wire logic frame_sync_input, // sync
    input wire logic sdo_out, // data bit
    input wire logic sdo_oe, // data enable
    input wire logic [13:0] analog_code, // level
    input wire logic sampling, // window
    input wire logic converting, // busy
    input wire logic powered_down, // asleep
    input wire logic [13:0] result_bits, // head word
    input wire logic result_valid, // word there
    input wire logic result_ready // taken
);
    int conv_cnt;
    int samp_cnt;
    // window lengths in ref_clk cycles
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            conv_cnt <= 0;
            samp_cnt <= 0;
        end
        else
        begin
            conv_cnt <= converting ? conv_cnt + 1 : 0;
            samp_cnt <= sampling ? samp_cnt + 1 : 0;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence cs_start;
        $fell(cs_n) && frame_sync_input;
    endsequence
    sequence conv_done;
        $fell(converting) && cs_n;
    endsequence
    chk_start_drives: assert property (cs_start |-> ##[2:8] sdo_oe)
        else $error("data line not driven after select fall");
    chk_release_tristates: assert property ($rose(cs_n) |-> ##[1:8] !sdo_oe)
        else $error("data line still driven after select rise");
    chk_drive_needs_select: assert property ($rose(sdo_oe) |-> !cs_n)
        else $error("data line driven while not selected");
    chk_sample_length: assert property ($fell(sampling) |-> samp_cnt >= 158 && samp_cnt <= 162)
        else $error("sampling window not 20 link clocks");
    chk_conv_follows: assert property ($fell(sampling) |-> ##[0:2] converting)
        else $error("conversion did not follow sampling");
    chk_no_overlap: assert property (!(sampling && converting))
        else $error("sampling and converting together");
    chk_conv_length: assert property (conv_done |-> conv_cnt >= 95 && conv_cnt <= 101)
        else $error("conversion not 20 oscillator ticks");
    chk_sleep_after: assert property (conv_done |-> ##[0:2] powered_down)
        else $error("no power-down after conversion");
    chk_wake_select: assert property ($fell(powered_down) |-> !cs_n)
        else $error("woke without select low");
    chk_result_holds: assert property (result_valid && !result_ready |=> result_valid && $stable(result_bits))
        else $error("unread result changed");
endmodule // serial_adc_frame_control_chk
bind serial_adc_frame_control serial_adc_frame_control_chk chk (.ref_clk(ref_clk), .rstn(rstn),
    .sclk(sclk), .cs_n(cs_n), .frame_sync_input(frame_sync_input), .sdo_out(sdo_out),
    .sdo_oe(sdo_oe), .analog_code(analog_code), .sampling(sampling), .converting(converting),
    .powered_down(powered_down), .result_bits(result_bits), .result_valid(result_valid),
    .result_ready(result_ready));

/* File: dv/adc_host_model.sv */
// host serial port model: select, frame sync and link clock
`timescale 1ns/10ps
module adc_host_model (
    output logic sclk, // link clock, idle low
    output logic cs_n, // select
    output logic frame_sync_input, // sync
    input wire logic sdo_out, // data bit
    input wire logic sdo_oe // data enable
);
    logic last = 1'b0;
    // no pull on the line, so a released line shows the inverse bit
    wire seen = sdo_oe ? sdo_out : ~last;
    always @*
        if (sdo_oe)
            last = sdo_out;
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        frame_sync_input = 1'b1;
    end
    // mode 0 select only, 1 sync only, 2 both; clock runs only in frames
    task automatic frame(input int mode, input int falls, output logic [15:0] word);
        int i;
        begin
            word = 16'h0000;
            // after a sync-only frame select and sync are still low: lift select first,
            // then sync, so neither lift looks like a frame start
            if (mode == 0 && (cs_n == 1'b0 || frame_sync_input == 1'b0))
            begin
                cs_n = 1'b1;
                #160 frame_sync_input = 1'b1;
                #160;
            end
            if (mode == 0)
                cs_n = 1'b0;
            else
            begin
                // select low before sync high, sync held a full clock
                frame_sync_input = 1'b0;
                #80 cs_n = 1'b0;
                #80 frame_sync_input = 1'b1;
                #160 frame_sync_input = 1'b0;
            end
            #80;
            // idle-low clock, bits taken on the falling edge
            for (i = 0; i < falls; i++)
            begin
                sclk = 1'b1;
                #80 if (i < 16) word = {word[14:0], seen};
                sclk = 1'b0;
                #80;
            end
            // select held through all falls before release
            if (mode != 1)
            begin
                cs_n = 1'b1;
                frame_sync_input = 1'b1;
            end
        end
    endtask
endmodule // adc_host_model

/* File: dv/serial_adc_frame_control_bench.sv */
// self-checking bench for the converter frame control
`timescale 1ns/10ps
module serial_adc_frame_control_bench;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [13:0] analog_code = 14'h0000;
    logic result_ready = 1'b0;
    wire sclk, cs_n, frame_sync_input, sdo_out, sdo_oe;
    wire sampling, converting, powered_down, result_valid;
    wire [13:0] result_bits;
    int bad_count = 0;
    int checks = 0;
    logic [15:0] fifo_exp[$];
    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;
    serial_adc_frame_control uut (.ref_clk(ref_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
        .frame_sync_input(frame_sync_input), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .analog_code(analog_code), .sampling(sampling), .converting(converting),
        .powered_down(powered_down), .result_bits(result_bits), .result_valid(result_valid),
        .result_ready(result_ready));
    adc_host_model host (.sclk(sclk), .cs_n(cs_n), .frame_sync_input(frame_sync_input),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // one frame off the clock phase; a full gap lets the conversion land in the fifo
    task automatic run(input int mode, input int falls, input logic [13:0] code,
        input logic [15:0] exp, input int gap);
        logic [15:0] w;
        @(posedge ref_clk) analog_code <= code;
        #7 host.frame(mode, falls, w);
        if (falls > 16) cmp({w[15:2], 2'b00}, {exp[15:2], 2'b00});
        repeat (8) @(posedge ref_clk);
        cmp({15'h0000, sdo_oe}, 16'h0000);
        // 32 fifo words plus the output register hold 33 results
        if (falls >= 24 && gap > 100 && fifo_exp.size() < 33) fifo_exp.push_back({2'b00, code});
        repeat (gap) @(posedge ref_clk);
    endtask
    task automatic t_init_and_pipeline;
        run(0, 3, 14'h0000, 16'h0000, 20);
        run(0, 24, 14'h1555, 16'h3fc0, 130);
        run(0, 24, 14'h2aaa, {14'h1555, 2'b00}, 130);
        run(0, 24, 14'h3fff, {14'h2aaa, 2'b00}, 130);
    endtask
    task automatic t_abort_and_modes;
        run(0, 24, 14'h0000, {14'h3fff, 2'b00}, 0);
        run(0, 24, 14'h0123, 16'h3fc0, 130);
        run(2, 24, 14'h0456, {14'h0123, 2'b00}, 130);
        run(1, 24, 14'h0789, {14'h0456, 2'b00}, 130);
        run(0, 24, 14'h0abc, {14'h0789, 2'b00}, 130);
    endtask
    // stall the reader past 32 words, then drain to empty
    task automatic t_fifo;
        int k;
        logic [13:0] prev;
        prev = 14'h0abc;
        for (k = 0; k < 27; k++)
        begin
            run(0, 24, 14'(k + 16), {prev, 2'b00}, 130);
            prev = 14'(k + 16);
        end
        @(posedge ref_clk) result_ready <= 1'b1;
        for (k = 0; k < 40; k++)
        begin
            @(negedge ref_clk);
            if (result_valid === 1'b1)
                cmp({2'b00, result_bits}, fifo_exp.size() > 0 ? fifo_exp.pop_front() : 16'hxxxx);
        end
        cmp(16'(fifo_exp.size()), 16'h0000);
    endtask
    initial
    begin
        repeat (4) @(posedge ref_clk);
        cmp({11'h000, sdo_oe, sampling, converting, powered_down, result_valid}, 16'h0002);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_init_and_pipeline();
        t_abort_and_modes();
        t_fifo();
        tally_and_finish();
    end
endmodule // serial_adc_frame_control_bench
